// ---- inc/lsl_pkg.sv ----
// Constants, register map and decoders for the line signal-loss monitor.
// Assumes a 200 MHz system clock and 8-bit registers, one per 32-bit word.
package lsl_pkg;
  localparam int unsigned CLK_HZ    = 200_000_000;
  localparam int unsigned FB_E1_HZ  = 32_000;
  localparam int unsigned FB_T1_HZ  = 24_125;
  localparam int unsigned FB_E1_CYC = CLK_HZ / FB_E1_HZ;
  localparam int unsigned FB_T1_CYC = CLK_HZ / FB_T1_HZ;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA0   = 8'hd8;
  localparam logic [7:0] IDX_RX_CFG  = 8'hf0;
  localparam logic [7:0] IDX_STATUS  = 8'hf8;
  localparam logic [7:0] IDX_THRESH  = 8'hf9;
  localparam logic [7:0] IDX_DETECT_RUN_LENGTH = 8'hfa;
  localparam logic [7:0] IDX_CLEAR_RUN_LENGTH = 8'hfb;
  localparam logic [7:0] IDX_INDEX   = 8'hfc;
  localparam logic [7:0] IDX_DIR     = 8'hfd;
  localparam logic [7:0] IDX_RD_PTR  = 8'hfe;
  localparam logic [7:0] IDX_EQ_CFG  = 8'hff;

  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_PER    = 8'h01;
  localparam logic [7:0] RST_INDEX  = 8'h00;
  localparam logic       RST_DIR    = 1'b1;
  localparam logic [7:0] RST_PTR    = 8'h00;
  localparam logic [7:0] RST_EQ_CFG = 8'h03;
  localparam logic [7:0] CFG_WMASK  = 8'hcf;

  localparam int DET_LSB  = 0;
  localparam int CLR_LSB  = 4;
  localparam int DIR_BIT  = 7;
  localparam int RATE_LSB = 0;
  localparam int WIN_LSB  = 6;
  localparam int HOLD_BIT = 0;
  localparam int ST_FLAG  = 7;
  localparam int ST_STATE = 6;
  localparam int ST_EN    = 5;
  localparam int ST_SETL  = 2;

  localparam int         RUN_SHIFT   = 4;
  localparam logic [8:0] SETTLE_BASE = 9'h020;
  localparam logic [7:0] DRIFT_MAX   = 8'h08;

  typedef enum logic [1:0] {ACC_IDLE, ACC_WRITE, ACC_READ, ACC_LOAD} lsl_acc_e;

  // Threshold code to level in half-dB steps
  function automatic logic [7:0] lsl_level_hdb(input logic [2:0] sel);
    logic [7:0] lvl;
    lvl = 8'h12;
    unique case (sel)
      3'h0: lvl = 8'h12;
      3'h1: lvl = 8'h1d;
      3'h2: lvl = 8'h28;
      3'h3: lvl = 8'h2c;
      3'h4: lvl = 8'h32;
      3'h5: lvl = 8'h3c;
      3'h6: lvl = 8'h3e;
      3'h7: lvl = 8'h46;
    endcase
    return lvl;
  endfunction
endpackage

// ---- design/lsl_eq_ram.sv ----
// Equalizer coefficient memory, one port, registered read data.
// Assumes the owner never reads and writes the same cycle.
`timescale 1ns/100ps
`default_nettype none
module lsl_eq_ram #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input  wire logic              clock_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule
`default_nettype wire

// ---- design/lsl_run_counter.sv ----
// Counts uninterrupted pulse intervals that meet a criterion.
// Assumes tick_i is a one-cycle strobe per pulse interval.
`timescale 1ns/100ps
`default_nettype none
module lsl_run_counter #(
  parameter int LEN_W = 8,
  parameter int SHIFT = 4
) (
  input  wire logic             clock_i,
  input  wire logic             clear_i,
  input  wire logic             tick_i,
  input  wire logic             meet_i,
  input  wire logic [LEN_W-1:0] length_i,
  output logic                  done_o
);
  localparam int CW = LEN_W + SHIFT;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  wire  [CW-1:0] target    = {length_i, {SHIFT{1'b0}}};
  wire  [CW-1:0] count_inc = count_reg + 1'b1;

  assign done_o = tick_i & meet_i & (count_inc >= target);

  always_comb begin
    count_next = count_reg;
    if (clear_i || done_o) begin
      count_next = '0;
    end else if (tick_i) begin
      count_next = meet_i ? count_inc : '0;
    end
  end

  always_ff @(posedge clock_i) begin
    count_reg <= count_next;
  end

  run_restart_a: assert property (@(posedge clock_i) disable iff (clear_i)
    tick_i && !meet_i |=> count_reg == '0)
    else $error("run count not restarted after failed interval");
endmodule
`default_nettype wire

// ---- design/lsl_line_monitor.sv ----
// Receive line signal-loss monitor and equalizer RAM access, AHB-Lite slave.
// Assumes line inputs come from the analog slicer, outside the clock domain.
//
// Overview of operation
// - Threshold code 000..111 picks a level from 9 dB up to 35 dB.
// - Declare loss and flag it after 16 x detect period intervals at/above level.
// - Clear loss after 16 x clear period intervals at/below the clear level.
// - Detect period is 8 bits, times sixteen, resets to one.
// - Clear period is 8 bits, times sixteen, resets to one.
// - Interface hold bit keeps all block registers except the status and receive config registers at reset values.
// - Writing the RAM index launches one read or write at that index.
// - A write stores the four data registers; a read loads them.
// - Direction bit 7 resets to one; one reads, zero writes.
// - Read-pointer write overwrites the counter; a read returns it.
// - Rate code 000 is the fastest loop rate; higher codes slow it.
// - Window code picks 32, 64, 128 or 256 stable periods before settled.
// - Flag sets on loss rising, clears on status read; the interrupt is the flag gated by enable.
`timescale 1ns/100ps
`default_nettype none
module lsl_line_monitor #(
  parameter int unsigned FB_E1_CYCLES = lsl_pkg::FB_E1_CYC,
  parameter int unsigned FB_T1_CYCLES = lsl_pkg::FB_T1_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        line_pulse_i,
  input  wire logic [7:0]  line_loss_i,
  input  wire logic [7:0]  cable_loss_i,
  input  wire logic        e1_mode_i,
  output logic             irq_o,
  output logic             signal_loss_o,
  output logic             equalizer_settled_o,
  output logic      [31:0] eq_coeff_o
);
  import lsl_pkg::*;

  // Bus slave: zero wait states, write lands at the end of the data phase
  logic        wr_pend_reg;
  logic [7:0]  wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic [7:0]  rd_mux;
  wire         take     = hsel_i & hready_i & htrans_i[1];
  wire  [7:0]  take_idx = haddr_i[9:2];
  wire         in_range = (haddr_i[31:10] == 22'h00_0000);
  wire         take_rd  = take & ~hwrite_i & in_range;
  wire         rd_clear = take_rd & (take_idx == IDX_STATUS);
  wire  [7:0]  wdata    = hwdata_i[7:0];

  function automatic logic wr_hit(input logic [7:0] idx);
    return wr_pend_reg && (wr_idx_reg == idx);
  endfunction

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else begin
      wr_pend_reg <= take & hwrite_i & in_range;
      wr_idx_reg  <= take_idx;
    end
  end

  // Registers held by the interface hold bit, plus the hold bit and the status enable
  logic       hold_reg;
  logic [2:0] det_sel_reg;
  logic [2:0] clr_sel_reg;
  logic [7:0] detect_run_length_reg;
  logic [7:0] clear_run_length_reg;
  logic [7:0] index_reg;
  logic       dir_reg;
  logic [7:0] ptr_reg;
  logic [7:0] cfg_reg;
  logic       enable_reg;
  wire        hold_rst = srst_i | hold_reg;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hold_reg <= 1'b0;
    end else if (wr_hit(IDX_RX_CFG)) begin
      hold_reg <= wdata[HOLD_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (hold_rst) begin
      det_sel_reg <= RST_THRESH[DET_LSB+:3];
      clr_sel_reg <= RST_THRESH[CLR_LSB+:3];
      detect_run_length_reg <= RST_PER;
      clear_run_length_reg <= RST_PER;
      index_reg   <= RST_INDEX;
      dir_reg     <= RST_DIR;
      cfg_reg     <= RST_EQ_CFG;
    end else begin
      if (wr_hit(IDX_THRESH)) begin
        det_sel_reg <= wdata[DET_LSB+:3];
        clr_sel_reg <= wdata[CLR_LSB+:3];
      end
      if (wr_hit(IDX_DETECT_RUN_LENGTH)) begin
        detect_run_length_reg <= wdata;
      end
      if (wr_hit(IDX_CLEAR_RUN_LENGTH)) begin
        clear_run_length_reg <= wdata;
      end
      if (wr_hit(IDX_INDEX)) begin
        index_reg <= wdata;
      end
      if (wr_hit(IDX_DIR)) begin
        dir_reg <= wdata[DIR_BIT];
      end
      if (wr_hit(IDX_EQ_CFG)) begin
        cfg_reg <= wdata & CFG_WMASK;
      end
    end
  end

  wire [2:0] rate_sel  = cfg_reg[RATE_LSB+:3];
  wire [1:0] valid_per = cfg_reg[WIN_LSB+:2];

  // Line inputs; the loss word is a slow analog code, so per-bit sync suffices
  logic [7:0] loss_meta_reg, loss_reg;
  logic [7:0] cable_meta_reg, cable_reg;
  logic       pulse_meta_reg, pulse_reg, pulse_old_reg;
  always_ff @(posedge clock_i) begin
    loss_meta_reg  <= line_loss_i;
    loss_reg       <= loss_meta_reg;
    cable_meta_reg <= cable_loss_i;
    cable_reg      <= cable_meta_reg;
    pulse_meta_reg <= line_pulse_i;
    pulse_reg      <= pulse_meta_reg;
    pulse_old_reg  <= pulse_reg;
  end
  wire pulse_tick = pulse_reg & ~pulse_old_reg;

  // Loss detection and clearance
  logic state_reg;
  logic flag_reg;
  logic run_done;
  wire [7:0] det_level  = lsl_level_hdb(det_sel_reg);
  wire [7:0] clr_level  = lsl_level_hdb(clr_sel_reg);
  wire       det_meet   = loss_reg >= det_level;
  wire       clr_meet   = loss_reg <= clr_level;
  wire       run_meet   = state_reg ? clr_meet : det_meet;
  wire [7:0] run_length = state_reg ? clear_run_length_reg : detect_run_length_reg;

  lsl_run_counter #(
    .LEN_W (8),
    .SHIFT (RUN_SHIFT)
  ) u_run (
    .clock_i  (clock_i),
    .clear_i  (hold_rst),
    .tick_i   (pulse_tick),
    .meet_i   (run_meet),
    .length_i (run_length),
    .done_o   (run_done)
  );

  wire flag_set  = run_done & ~state_reg;
  wire flag_clr  = rd_clear | (wr_hit(IDX_STATUS) & wdata[ST_FLAG]);
  wire flag_next = flag_set | (flag_reg & ~flag_clr);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg  <= 1'b0;
      flag_reg   <= 1'b0;
      enable_reg <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      if (run_done) begin
        state_reg <= ~state_reg;
      end
      flag_reg <= flag_next;
      if (wr_hit(IDX_STATUS)) begin
        enable_reg <= wdata[ST_EN];
      end
      irq_o <= flag_next & enable_reg;
    end
  end

  // Feedback loop rate: base period stretched by code plus one
  logic [13:0] pre_reg;
  logic [2:0]  div_reg;
  wire  [13:0] pre_top  = e1_mode_i ? 14'(FB_E1_CYCLES - 1) : 14'(FB_T1_CYCLES - 1);
  wire         pre_wrap = pre_reg >= pre_top;
  wire         div_wrap = div_reg >= rate_sel;
  wire         fb_tick  = pre_wrap & div_wrap;
  always_ff @(posedge clock_i) begin
    if (hold_rst) begin
      pre_reg <= 14'h0000;
      div_reg <= 3'h0;
    end else begin
      pre_reg <= pre_wrap ? 14'h0000 : pre_reg + 14'h0001;
      if (pre_wrap) begin
        div_reg <= div_wrap ? 3'h0 : div_reg + 3'h1;
      end
    end
  end

  // Settling watch on the cable loss code
  logic [7:0] ref_reg;
  logic [8:0] stable_reg;
  logic [8:0] stable_next;
  wire  [8:0] window = SETTLE_BASE << valid_per;
  wire  [7:0] drift  = (cable_reg > ref_reg) ? cable_reg - ref_reg : ref_reg - cable_reg;
  wire        moved  = drift > DRIFT_MAX;
  always_comb begin
    stable_next = stable_reg;
    if (fb_tick) begin
      if (moved) begin
        stable_next = 9'h000;
      end else if (stable_reg < window) begin
        stable_next = stable_reg + 9'h001;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (hold_rst) begin
      ref_reg    <= 8'h00;
      stable_reg <= 9'h000;
      equalizer_settled_o <= 1'b0;
    end else begin
      if (fb_tick && moved) begin
        ref_reg <= cable_reg;
      end
      stable_reg <= stable_next;
      equalizer_settled_o <= stable_next >= window;
    end
  end

  // Indirect RAM access; the pointer port has the RAM whenever idle
  lsl_acc_e    acc_reg, acc_next;
  logic [7:0]  data_reg [4];
  logic [31:0] ram_q;
  logic        ptr_rd_reg;
  wire         we_index = wr_hit(IDX_INDEX);
  wire         ram_we   = (acc_reg == ACC_WRITE);
  wire  [7:0]  ram_addr = (acc_reg == ACC_IDLE) ? ptr_reg : index_reg;
  wire  [31:0] ram_wd   = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};

  always_comb begin
    acc_next = acc_reg;
    unique case (acc_reg)
      ACC_IDLE:  if (we_index) begin
        acc_next = dir_reg ? ACC_READ : ACC_WRITE;
      end
      ACC_WRITE: acc_next = ACC_IDLE;
      ACC_READ:  acc_next = ACC_LOAD;
      ACC_LOAD:  acc_next = ACC_IDLE;
    endcase
  end

  lsl_eq_ram #(
    .ADDR_W (8),
    .DATA_W (32)
  ) u_ram (
    .clock_i (clock_i),
    .we_i    (ram_we),
    .addr_i  (ram_addr),
    .wdata_i (ram_wd),
    .rdata_o (ram_q)
  );

  always_ff @(posedge clock_i) begin
    if (hold_rst) begin
      acc_reg    <= ACC_IDLE;
      ptr_reg    <= RST_PTR;
      ptr_rd_reg <= 1'b0;
      eq_coeff_o <= 32'h0000_0000;
    end else begin
      acc_reg    <= acc_next;
      ptr_rd_reg <= (acc_reg == ACC_IDLE);
      if (wr_hit(IDX_RD_PTR)) begin
        ptr_reg <= wdata;
      end else if (fb_tick) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
      if (ptr_rd_reg) begin
        eq_coeff_o <= ram_q;
      end
    end
  end

  // A load landing with a data write wins; software spacing avoids the clash
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 4; i++) begin
      if (hold_rst) begin
        data_reg[i] <= 8'h00;
      end else if (acc_reg == ACC_LOAD) begin
        data_reg[i] <= ram_q[8*i+:8];
      end else if (wr_hit(IDX_DATA0 + 8'(i))) begin
        data_reg[i] <= wdata;
      end
    end
  end

  // Read mux, captured in the address phase
  always_comb begin
    rd_mux = 8'h00;
    unique case (take_idx)
      IDX_DATA0:         rd_mux = data_reg[0];
      IDX_DATA0 + 8'h01: rd_mux = data_reg[1];
      IDX_DATA0 + 8'h02: rd_mux = data_reg[2];
      IDX_DATA0 + 8'h03: rd_mux = data_reg[3];
      IDX_RX_CFG:  rd_mux = {7'h00, hold_reg};
      IDX_STATUS:  rd_mux = {flag_reg, state_reg, enable_reg, 2'h0,
                             equalizer_settled_o, 2'h0};
      IDX_THRESH:  rd_mux = {1'b0, clr_sel_reg, 1'b0, det_sel_reg};
      IDX_DETECT_RUN_LENGTH: rd_mux = detect_run_length_reg;
      IDX_CLEAR_RUN_LENGTH: rd_mux = clear_run_length_reg;
      IDX_INDEX:   rd_mux = index_reg;
      IDX_DIR:     rd_mux = {dir_reg, 7'h00};
      IDX_RD_PTR:  rd_mux = ptr_reg;
      IDX_EQ_CFG:  rd_mux = cfg_reg;
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_o   <= 1'b0;
      hresp_o       <= 1'b0;
      signal_loss_o <= 1'b0;
    end else begin
      if (take_rd) begin
        hrdata_reg <= {24'h00_0000, rd_mux};
      end
      hreadyout_o   <= 1'b1;
      hresp_o       <= 1'b0;
      signal_loss_o <= state_reg;
    end
  end
  assign hrdata_o = hrdata_reg;

  // Checks
  logic [11:0] run_h;
  always_ff @(posedge clock_i) begin
    if (hold_rst || run_done || (pulse_tick && !run_meet)) begin
      run_h <= 12'h000;
    end else if (pulse_tick) begin
      run_h <= run_h + 12'h001;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence read_launch_s;
    acc_reg == ACC_IDLE && we_index && dir_reg;
  endsequence
  sequence read_finish_s;
    acc_reg == ACC_READ ##1 acc_reg == ACC_LOAD ##1 acc_reg == ACC_IDLE;
  endsequence

  level_table_a: assert property (det_sel_reg == 3'h7 |-> det_level == 8'h46)
    else $error("detect level table wrong");
  detect_run_a: assert property ($rose(state_reg) && !$past(hold_reg) |->
    13'($past(run_h)) + 13'h0001 >= {1'b0, $past(detect_run_length_reg), 4'h0})
    else $error("loss declared before full detect run");
  clear_run_a: assert property ($fell(state_reg) && !$past(hold_reg) |->
    13'($past(run_h)) + 13'h0001 >= {1'b0, $past(clear_run_length_reg), 4'h0})
    else $error("loss cleared before full clear run");
  hold_reset_a: assert property (hold_reg |=> detect_run_length_reg == RST_PER &&
    clear_run_length_reg == RST_PER && dir_reg == RST_DIR && cfg_reg == RST_EQ_CFG)
    else $error("held register left its reset value");
  ram_read_a: assert property (read_launch_s and !hold_rst |=> read_finish_s)
    else $error("ram read sequence broken");
  ram_write_a: assert property (acc_reg == ACC_IDLE && we_index && !dir_reg
    && !hold_rst |=> ram_we ##1 acc_reg == ACC_IDLE)
    else $error("ram write not issued");
  ptr_write_a: assert property (wr_hit(IDX_RD_PTR) && !hold_rst |=>
    ptr_reg == $past(wdata))
    else $error("read pointer not overwritten");
  settled_win_a: assert property (equalizer_settled_o |-> stable_reg >= $past(window))
    else $error("settled without full window");
  flag_rise_a: assert property ($rose(state_reg) |-> flag_reg ##1
    (irq_o == (flag_reg & $past(enable_reg))))
    else $error("loss flag or interrupt missing");
  irq_gate_a: assert property (irq_o |-> $past(enable_reg))
    else $error("interrupt while disabled");
endmodule
`default_nettype wire

// ---- verification/lsl_line_source.sv ----
// Slicer model: pulse intervals and attenuation level seen by the loss monitor.
// Assumes a free-running line, one interval every PERIOD clocks.
`timescale 1ns/100ps
`default_nettype none
module lsl_line_source #(
  parameter int PERIOD = 16
) (
  input  wire logic       clock_i,
  input  wire logic [7:0] level_i,
  input  wire logic [7:0] cable_i,
  output logic            line_pulse_o,
  output logic      [7:0] line_loss_o,
  output logic      [7:0] cable_loss_o
);
  int phase;
  initial begin
    phase = 0;
    line_pulse_o = 1'b0;
    line_loss_o = 8'h00;
    cable_loss_o = 8'h00;
  end
  // Falling-edge updates keep the line unrelated to the sampling edge
  always @(negedge clock_i) begin
    phase        <= (phase == PERIOD - 1) ? 0 : phase + 1;
    line_pulse_o <= (phase < PERIOD / 2);
    line_loss_o  <= level_i;
    cable_loss_o <= cable_i;
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the line signal-loss monitor and its RAM access.
// Assumes the slicer model drives the line and the bench is the only bus master.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import lsl_pkg::*;
  localparam int         E1C = 8;
  localparam int         T1C = 10;
  localparam logic [7:0] LVL [8] = '{8'h12, 8'h1d, 8'h28, 8'h2c, 8'h32, 8'h3c, 8'h3e, 8'h46};
  localparam logic [7:0] REGS [7] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
  localparam logic [7:0] RSTV [7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h03};
  localparam logic [7:0] MASK [7] = '{8'h77, 8'hff, 8'hff, 8'hff, 8'h80, 8'hff, 8'hcf};
  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic        e1_mode = 1'b1;
  logic [7:0]  level   = 8'h00;
  logic [7:0]  cable   = 8'h40;
  logic [31:0] hrdata;
  logic [31:0] coeff;
  logic        hready;
  logic        hresp;
  logic        line_pulse;
  logic [7:0]  line_loss;
  logic [7:0]  cable_loss;
  logic        irq;
  logic        sig_loss;
  logic        settled;
  int          fails      = 0;
  int          n_compared = 0;

  lsl_line_source #(.PERIOD(16)) i_line (.clock_i(clock_i), .level_i(level), .cable_i(cable),
    .line_pulse_o(line_pulse), .line_loss_o(line_loss), .cable_loss_o(cable_loss));

  lsl_line_monitor #(.FB_E1_CYCLES(E1C), .FB_T1_CYCLES(T1C)) i_dut (
    .clock_i(clock_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .line_pulse_i(line_pulse),
    .line_loss_i(line_loss), .cable_loss_i(cable_loss), .e1_mode_i(e1_mode), .irq_o(irq),
    .signal_loss_o(sig_loss), .equalizer_settled_o(settled), .eq_coeff_o(coeff));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Bounded so that a slave stuck not ready ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h00_0000, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    wait_ready();
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    xfer(1'b1, idx, d, unused);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask

  // Level changes land mid-interval, well clear of the pulse edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge line_pulse);
      repeat (8) @(posedge clock_i);
    end
  endtask

  initial begin
    #400_000;
    fails++;
    close_out();
  end

  initial begin
    logic [7:0]  d;
    logic [7:0]  w;
    logic [7:0]  p0;
    logic [7:0]  ram_a [3];
    logic [31:0] ram_d [3];
    logic        en;
    void'($urandom(94273));
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    wr(IDX_RX_CFG, 8'h01);
    for (int i = 0; i < 7; i++) begin
      rd(REGS[i], d);
      check(d, RSTV[i]);
      wr(REGS[i], 8'($urandom()));
      rd(REGS[i], d);
      check(d, RSTV[i]);
    end
    wr(IDX_RX_CFG, 8'h00);
    for (int i = 0; i < 7; i++) begin
      w = 8'($urandom());
      if (i == 0) w[6:4] = w[2:0];
      if (i == 6) w[3] = 1'b1;
      wr(REGS[i], w);
      rd(REGS[i], d);
      if (i != 5) check(d, w & MASK[i]);
      else check(32'(d === w || d === w + 8'h01), 32'h1);
    end
    rd(8'h10, d);
    check(d, 8'h00);
    // Pointer advance over four loop periods for every rate code
    for (int r = 0; r < 8; r++) begin
      e1_mode <= r[0];
      wr(IDX_EQ_CFG, 8'h08 | 8'(r));
      rd(IDX_RD_PTR, p0);
      repeat ((r[0] ? E1C : T1C) * (r + 1) * 4 - 2) @(posedge clock_i);
      rd(IDX_RD_PTR, d);
      check(8'(d - p0), 8'h04);
    end
    e1_mode <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      wr(IDX_EQ_CFG, 8'(v << 6) | 8'h08);
      cable <= cable + 8'h20;
      repeat ((32 << v) * E1C - 32) @(posedge clock_i);
      check(settled, 1'b0);
      repeat (96) @(posedge clock_i);
      check(settled, 1'b1);
      rd(IDX_STATUS, d);
      check(d[2], 1'b1);
    end
    wr(IDX_DIR, 8'h00);
    for (int k = 0; k < 3; k++) begin
      ram_a[k] = {2'(k), 6'($urandom())};
      ram_d[k] = $urandom();
      for (int b = 0; b < 4; b++) wr(IDX_DATA0 + 8'(b), ram_d[k][8*b +: 8]);
      wr(IDX_INDEX, ram_a[k]);
      repeat (4) @(posedge clock_i);
    end
    wr(IDX_DIR, 8'h80);
    for (int b = 0; b < 4; b++) wr(IDX_DATA0 + 8'(b), 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_INDEX, ram_a[k]);
      repeat (4) @(posedge clock_i);
      for (int b = 0; b < 4; b++) begin
        rd(IDX_DATA0 + 8'(b), d);
        check(d, ram_d[k][8*b +: 8]);
      end
    end
    // Slow loop so a pointer write lands well clear of the next advance
    wr(IDX_EQ_CFG, 8'h0f);
    for (int k = 0; k < 3; k++) begin
      rd(IDX_RD_PTR, p0);
      d = p0;
      for (int n = 0; n < 40 && d == p0; n++) rd(IDX_RD_PTR, d);
      wr(IDX_RD_PTR, ram_a[k]);
      repeat (3) @(posedge clock_i);
      check(coeff, ram_d[k]);
      check(hresp, 1'b0);
    end
    wr(IDX_DETECT_RUN_LENGTH, 8'h01);
    wr(IDX_CLEAR_RUN_LENGTH, 8'h02);
    for (int c = 0; c < 8; c++) begin
      en = c[0];
      wr(IDX_THRESH, {1'b0, 3'(c), 1'b0, 3'(c)});
      wr(IDX_STATUS, {2'b00, en, 5'h00});
      level <= LVL[c];
      pulses(10);
      level <= LVL[c] - 8'h01;
      pulses(1);
      level <= LVL[c];
      pulses(15);
      rd(IDX_STATUS, d);
      check(d & 8'he0, {2'b00, en, 5'h00});
      pulses(1);
      check(irq, en);
      if (c[1]) wr(IDX_STATUS, {2'b10, en, 5'h00});
      rd(IDX_STATUS, d);
      check(d & 8'he0, {~c[1], 1'b1, en, 5'h00});
      check(sig_loss, 1'b1);
      rd(IDX_STATUS, d);
      check(d & 8'he0, {2'b01, en, 5'h00});
      check(irq, 1'b0);
      pulses(31);
      rd(IDX_STATUS, d);
      check(d[6], 1'b1);
      pulses(1);
      rd(IDX_STATUS, d);
      check(d[6], 1'b0);
      check(sig_loss, 1'b0);
    end
    close_out();
  end
endmodule
`default_nettype wire
